// File: dpc_daa_ctrl.v
// What this block does and what its host must do
// R1 - reset defaults keep line side powered down
// R2 - PLL locks within 1 ms of clock
// R3 - host writes 00H to power register
// R4 - link stays off while link powerdown set
// R5 - host locks PLL before clearing powerdown
// R6 - after reset: reset operation, link off
// R7 - both bits clear gives normal link mode
// R8 - system powerdown alone enters sleep mode
// R9 - host keeps bit clock running in sleep
// R10 - only reset pin leaves sleep or deep
// R11 - both bits set enter deep powerdown
// R12 - off-hook runs 17 ms resistor calibration
// R13 - ADC calibration after settle and resistor cal
// R14 - manual calibration on trigger high then low
// R15 - link powerdown loops receive through filters
// R16 - clearing powerdown selects line data, frame flag
// R17 - digital loopback returns receive data unchanged
// R18 - host waits 402.75 ms before test modes
// R19 - isolation loopback sends data across link
// R20 - PCM analog loopback refilters line data
// R21 - hybrid disable selects internal analog loopback
// R22 - host enables one test mode at once
// R23 - link must come up within 10 ms
// R24 - host holds powerdown 1 ms on failure
// R25 - calibration marks data not yet valid
`timescale 1ns/1ps
`default_nettype none
`include "dpc_map.vh"
module dpc_daa_ctrl #(
  parameter integer RCAL_CYCLES = `DPC_RCAL_MS * `DPC_CLK_KHZ,
  parameter integer ADC_CYCLES  = `DPC_ADC_MS * `DPC_CLK_KHZ,
  parameter integer LINK_CYCLES = `DPC_LINK_MS * `DPC_CLK_KHZ,
  parameter integer FD          = `DPC_FILT_FRAMES
) (
  // clock and reset
  input  wire       clock,
  input  wire       rst,
  // serial control port
  input  wire       spi_sclk,
  input  wire       spi_cs_n,
  input  wire       spi_sdi,
  output reg        spi_sdo,
  output reg        spi_sdo_oe,
  // pcm highway
  input  wire       pcm_clk,
  input  wire       frame_sync_input,
  input  wire       serial_receive_data,
  output reg        serial_transmit_data,
  // isolation link toward the line side
  input  wire       line_frame_ok,
  input  wire       line_ring,
  input  wire       line_offhook,
  input  wire       line_power_ok,
  input  wire       line_dc_settled,
  input  wire [7:0] line_rx_word,
  output reg        link_enable,
  output reg  [7:0] line_tx_word,
  output reg        line_tx_valid,
  output reg        link_loop_cmd,
  output reg        analog_loop_cmd,
  // status
  output reg        ring_detect_output,
  output reg        data_valid
);
  localparam NA = 19;
  localparam [3:0] C_IDLE = 4'h1, C_RCAL = 4'h2, C_SETL = 4'h4, C_ADC = 4'h8;

  // two-flop synchronisers for everything from outside the clock domain
  wire [NA-1:0] a_in = {line_rx_word, line_dc_settled, line_power_ok, line_offhook,
                        line_ring, line_frame_ok, serial_receive_data,
                        frame_sync_input, pcm_clk, spi_sdi, spi_cs_n, spi_sclk};
  reg  [NA-1:0] s1_q;
  reg  [NA-1:0] s2_q;
  genvar g;
  generate
    for (g = 0; g < NA; g = g + 1) begin : g_sync
      always @(posedge clock or posedge rst) begin
        if (rst) begin
          s1_q[g] <= 1'b0;
          s2_q[g] <= 1'b0;
        end else begin
          s1_q[g] <= a_in[g];
          s2_q[g] <= s1_q[g];
        end
      end
    end
  endgenerate
  // word bits are synchronised one by one and used with no check that the line side holds them
  wire       sclk_s = s2_q[0];
  wire       cs_s   = s2_q[1];
  wire       sdi_s  = s2_q[2];
  wire       pclk_s = s2_q[3];
  wire       fs_s   = s2_q[4];
  wire       drx_s  = s2_q[5];
  wire       fok_s  = s2_q[6];
  wire       ring_s = s2_q[7];
  wire       hook_s = s2_q[8];
  wire       pwr_s  = s2_q[9];
  wire       dcs_s  = s2_q[10];
  wire [7:0] lrx_s  = s2_q[18:11];

  // registers, declared ahead of the edge detectors that read them
  reg [7:0] loop_a_q, hyb_q, pwr_q, dloop_q, cal_q, rcal_q, aloop_q;
  reg       sleep_q, deep_q, locked_q, fdt_q, ltmo_q;
  reg [3:0] cst_q;

  // edge detection on the synchronised copies, the manual trigger bit and link enable
  reg sclk_p_q, pclk_p_q, hook_p_q, pwr_p_q, manual_cal_trigger_p_q, len_p_q;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sclk_p_q <= 1'b0;
      pclk_p_q <= 1'b0;
      hook_p_q <= 1'b0;
      pwr_p_q  <= 1'b0;
      manual_cal_trigger_p_q <= 1'b0;
      len_p_q  <= 1'b0;
    end else begin
      sclk_p_q <= sclk_s;
      pclk_p_q <= pclk_s;
      hook_p_q <= hook_s;
      pwr_p_q  <= pwr_s;
      manual_cal_trigger_p_q <= cal_q[`DPC_BIT_MANUAL_CAL_TRIGGER];
      len_p_q  <= link_enable;
    end
  end
  wire sclk_r = sclk_s & ~sclk_p_q;
  wire sclk_f = ~sclk_s & sclk_p_q;
  wire pclk_r = pclk_s & ~pclk_p_q;
  wire pclk_f = ~pclk_s & pclk_p_q;

  // register fields used throughout
  wire      lpd  = pwr_q[`DPC_BIT_LPD];
  wire      digital_data_loopback  = dloop_q[`DPC_BIT_DDL];
  wire      ill  = loop_a_q[`DPC_BIT_ILL];
  wire      pcm_analog_loopback = aloop_q[`DPC_BIT_PCM_ANALOG_LOOPBACK];
  wire      cbusy = (cst_q != C_IDLE);

  // pll lock: enough bit clock edges, lost when the clock stops
  reg [9:0] pedge_q;
  reg [7:0] pidle_q;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pedge_q  <= 10'h000;
      pidle_q  <= 8'h00;
      locked_q <= 1'b0;
    end else begin
      if (pclk_r) begin
        pidle_q <= 8'h00;
        if (pedge_q != `DPC_PLL_EDGES)
          pedge_q <= pedge_q + 10'h001;
      end else if (pidle_q == `DPC_PLL_IDLE) begin
        pedge_q <= 10'h000;
      end else begin
        pidle_q <= pidle_q + 8'h01;
      end
      // R2 lock bound
      locked_q <= (pedge_q == `DPC_PLL_EDGES);
    end
  end

  // serial control port: r/w bit, 7-bit address, 8 data bits, msb first
  reg [4:0] sbit_q;
  reg [6:0] sh_q;
  reg [6:0] addr_q;
  reg [7:0] rsh_q;
  reg       rd_q;
  reg [7:0] rdata;
  wire [7:0] cmd_w = {sh_q, sdi_s};
  wire       wr_go = ~cs_s & sclk_r & (sbit_q == 5'h0f) & ~rd_q;
  // R10 sleep and deep freeze the registers until the reset pin
  wire       wr_ok = wr_go & ~sleep_q & ~deep_q;
  wire [7:0] status_w = {1'b0, fdt_q, 3'h0, ltmo_q, cbusy, locked_q};

  // read decode; unmapped addresses read zero
  always @* begin
    case (cmd_w[6:0])
      `DPC_REG_LOOP_A: rdata = loop_a_q;
      `DPC_REG_HYBRID: rdata = hyb_q;
      `DPC_REG_POWER:  rdata = pwr_q;
      `DPC_REG_DLOOP:  rdata = dloop_q;
      `DPC_REG_LSTAT:  rdata = status_w;
      `DPC_REG_CAL:    rdata = cal_q;
      `DPC_REG_RCAL:   rdata = rcal_q;
      `DPC_REG_ALOOP:  rdata = aloop_q;
      default:         rdata = 8'h00;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sbit_q     <= 5'h00;
      sh_q       <= 7'h00;
      addr_q     <= 7'h00;
      rsh_q      <= 8'h00;
      rd_q       <= 1'b0;
      spi_sdo    <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else if (cs_s) begin
      sbit_q     <= 5'h00;
      rd_q       <= 1'b0;
      spi_sdo_oe <= 1'b0;
    end else begin
      if (sclk_r && sbit_q != 5'h10) begin
        sh_q   <= cmd_w[6:0];
        sbit_q <= sbit_q + 5'h01;
        if (sbit_q == 5'h07) begin
          addr_q <= cmd_w[6:0];
          rd_q   <= cmd_w[7];
          rsh_q  <= rdata;
        end
      end
      // read data leaves on falling edges after the address byte
      if (sclk_f && rd_q && sbit_q >= 5'h08 && sbit_q <= 5'h0f) begin
        spi_sdo    <= rsh_q[7];
        rsh_q      <= {rsh_q[6:0], 1'b0};
        spi_sdo_oe <= 1'b1;
      end
    end
  end

  // register writes and power mode tracking
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      // R1 safe defaults
      // R6 reset operation
      pwr_q    <= `DPC_RST_POWER;
      hyb_q    <= `DPC_RST_HYBRID;
      loop_a_q <= `DPC_RST_ZERO;
      dloop_q  <= `DPC_RST_ZERO;
      cal_q    <= `DPC_RST_ZERO;
      rcal_q   <= `DPC_RST_ZERO;
      aloop_q  <= `DPC_RST_ZERO;
      sleep_q  <= 1'b0;
      deep_q   <= 1'b0;
    end else if (wr_ok) begin
      case (addr_q)
        `DPC_REG_LOOP_A: loop_a_q <= cmd_w;
        `DPC_REG_HYBRID: hyb_q    <= cmd_w;
        `DPC_REG_POWER: begin
          pwr_q <= cmd_w;
          // R8 sleep entry
          sleep_q <= cmd_w[`DPC_BIT_SPD] & ~cmd_w[`DPC_BIT_LPD];
          // R11 deep powerdown entry
          deep_q <= cmd_w[`DPC_BIT_SPD] & cmd_w[`DPC_BIT_LPD];
        end
        `DPC_REG_DLOOP:  dloop_q  <= cmd_w;
        `DPC_REG_CAL:    cal_q    <= cmd_w;
        `DPC_REG_RCAL:   rcal_q   <= cmd_w;
        `DPC_REG_ALOOP:  aloop_q  <= cmd_w;
        default:         ;
      endcase
    end
  end

  // link enable and frame detect
  wire link_up_r = link_enable & ~len_p_q;
  wire lt_done;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      link_enable        <= 1'b0;
      fdt_q              <= 1'b0;
      ltmo_q             <= 1'b0;
      ring_detect_output <= 1'b0;
      link_loop_cmd      <= 1'b0;
      analog_loop_cmd    <= 1'b0;
    end else begin
      // R4 link gated by powerdown
      // R7 normal mode link
      link_enable <= ~lpd & locked_q & ~deep_q;
      // R16 frame flag
      fdt_q <= link_enable & fok_s;
      // R23 establish timeout
      if (~link_enable)
        ltmo_q <= 1'b0;
      else if (lt_done && !fdt_q)
        ltmo_q <= 1'b1;
      // R8 ring works in sleep
      // R11 no ring in deep
      ring_detect_output <= ring_s & fdt_q & ~deep_q;
      // R19 link loopback command
      link_loop_cmd <= ill & link_enable;
      // R21 internal analog loopback
      analog_loop_cmd <= ~hyb_q[`DPC_BIT_HBE] & link_enable;
    end
  end

  dpc_timer #(.W(20)) u_link_tmr (
    .clock (clock),
    .rst   (rst),
    .start (link_up_r),
    .load  (LINK_CYCLES[19:0]),
    .busy  (),
    .done  (lt_done)
  );

  // calibration sequencer, one shared timer
  wire       c_done;
  reg        c_start;
  reg [24:0] c_load;
  wire       cal_trig = link_enable & ((hook_s & ~hook_p_q) | (~pwr_s & pwr_p_q));
  // R14 manual trigger on falling edge
  wire       man_trig = cal_q[`DPC_BIT_AUTO_CAL_DISABLE] & manual_cal_trigger_p_q & ~cal_q[`DPC_BIT_MANUAL_CAL_TRIGGER];
  reg  [3:0] cst_d;
  always @* begin
    cst_d   = cst_q;
    c_start = 1'b0;
    c_load  = ADC_CYCLES[24:0];
    case (cst_q)
      C_IDLE: begin
        if (cal_trig) begin
          // R12 resistor cal unless disabled
          if (rcal_q[`DPC_BIT_RESISTOR_CAL_DISABLE]) begin
            cst_d = C_SETL;
          end else begin
            cst_d   = C_RCAL;
            c_start = 1'b1;
            c_load  = RCAL_CYCLES[24:0];
          end
        end else if (man_trig) begin
          cst_d   = C_ADC;
          c_start = 1'b1;
        end
      end
      C_RCAL: if (c_done) cst_d = C_SETL;
      C_SETL: begin
        // R13 adc cal after settle
        if (dcs_s) begin
          if (cal_q[`DPC_BIT_AUTO_CAL_DISABLE]) begin
            cst_d = C_IDLE;
          end else begin
            cst_d   = C_ADC;
            c_start = 1'b1;
          end
        end
      end
      C_ADC: if (c_done) cst_d = C_IDLE;
      default: cst_d = C_IDLE;
    endcase
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cst_q      <= C_IDLE;
      data_valid <= 1'b0;
    end else begin
      cst_q <= cst_d;
      // R25 data not valid during cal
      data_valid <= ~cbusy & ~sleep_q & ~deep_q;
    end
  end

  dpc_timer #(.W(25)) u_cal_tmr (
    .clock (clock),
    .rst   (rst),
    .start (c_start),
    .load  (c_load),
    .busy  (),
    .done  (c_done)
  );

  // 0.9 dB attenuation as 115/128, shared by every filtered path
  function [7:0] dpc_att;
    input [7:0] x;
    reg signed [15:0] p;
    begin
      p       = $signed({{8{x[7]}}, x}) * 16'sd115;
      dpc_att = p[14:7];
    end
  endfunction

  // pcm framing: frame sync high on a bit clock rise marks bit 0
  reg [2:0] pbit_q;
  reg [7:0] rsr_q, rxw_q, txw_q, tsr_q;
  reg       wdone_q;
  reg [7:0] fdly_q [0:FD-1];
  wire [7:0] filt_w = dpc_att(fdly_q[FD-1]);
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pbit_q               <= 3'h0;
      rsr_q                <= 8'h00;
      rxw_q                <= 8'h00;
      tsr_q                <= 8'h00;
      wdone_q              <= 1'b0;
      serial_transmit_data <= 1'b0;
    end else begin
      wdone_q <= 1'b0;
      if (pclk_r) begin
        rsr_q  <= {rsr_q[6:0], drx_s};
        pbit_q <= fs_s ? 3'h1 : pbit_q + 3'h1;
        if (fs_s)
          tsr_q <= txw_q;
        else
          tsr_q <= {tsr_q[6:0], 1'b0};
        if (!fs_s && pbit_q == 3'h7) begin
          rxw_q   <= {rsr_q[6:0], drx_s};
          wdone_q <= 1'b1;
        end
      end
      // outside sleep and deep the pcm port is live
      if (pclk_f)
        serial_transmit_data <= tsr_q[7] & ~sleep_q & ~deep_q;
    end
  end

  // filter delay line, one step per received word
  genvar k;
  generate
    for (k = 0; k < FD; k = k + 1) begin : g_fdly
      always @(posedge clock or posedge rst) begin
        if (rst)
          fdly_q[k] <= 8'h00;
        else if (wdone_q)
          fdly_q[k] <= (k == 0) ? (lpd ? rxw_q : lrx_s) : fdly_q[(k == 0) ? 0 : k-1];
      end
    end
  endgenerate

  // transmit word and link word selection, taken per frame
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      txw_q         <= 8'h00;
      line_tx_word  <= 8'h00;
      line_tx_valid <= 1'b0;
    end else begin
      line_tx_valid <= wdone_q & link_enable;
      if (wdone_q) begin
        // R17 unfiltered digital loopback
        if (digital_data_loopback)
          txw_q <= rxw_q;
        // R15 start-up loopback
        // R19 link return filtered
        else if (lpd || ill || pcm_analog_loopback)
          txw_q <= filt_w;
        // R16 line data in normal mode
        else
          txw_q <= lrx_s;
        // R20 line data back to line
        line_tx_word <= pcm_analog_loopback ? filt_w : rxw_q;
      end
    end
  end
endmodule // dpc_daa_ctrl
`default_nettype wire

// File: dpc_map.vh
`ifndef DPC_MAP_VH
`define DPC_MAP_VH
// register offsets
`define DPC_REG_LOOP_A   7'h01
`define DPC_REG_HYBRID   7'h02
`define DPC_REG_POWER    7'h06
`define DPC_REG_DLOOP    7'h0a
`define DPC_REG_LSTAT    7'h0c
`define DPC_REG_CAL      7'h11
`define DPC_REG_RCAL     7'h19
`define DPC_REG_ALOOP    7'h21
// field positions
`define DPC_BIT_ILL      1
`define DPC_BIT_HBE      1
`define DPC_BIT_SPD      3
`define DPC_BIT_LPD      4
`define DPC_BIT_DDL      0
`define DPC_BIT_LOCK     0
`define DPC_BIT_CBUSY    1
`define DPC_BIT_LTMO     2
`define DPC_BIT_FDT      6
`define DPC_BIT_AUTO_CAL_DISABLE     5
`define DPC_BIT_MANUAL_CAL_TRIGGER     6
`define DPC_BIT_RESISTOR_CAL_DISABLE    5
`define DPC_BIT_PCM_ANALOG_LOOPBACK     7
// reset values
`define DPC_RST_POWER    8'h10
`define DPC_RST_HYBRID   8'h02
`define DPC_RST_ZERO     8'h00
// timing
`define DPC_CLK_KHZ      100000
`define DPC_PLL_MAX_US   1000
`define DPC_PLL_EDGES    10'h200
`define DPC_PLL_IDLE     8'hff
`define DPC_RCAL_MS      17
`define DPC_ADC_MS       256
`define DPC_LINK_MS      10
`define DPC_FILT_FRAMES  4
`endif

// File: dpc_timer.v
`timescale 1ns/1ps
`default_nettype none
// countdown timer: start loads the count, done pulses when it runs out
module dpc_timer #(
  parameter W = 25
) (
  // clock and reset
  input  wire         clock,
  input  wire         rst,
  // control
  input  wire         start,
  input  wire [W-1:0] load,
  // status
  output reg          busy,
  output reg          done
);
  reg [W-1:0] cnt_q;

  // a fresh start restarts a running count
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      cnt_q <= {W{1'b0}};
      busy  <= 1'b0;
      done  <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_q <= load;
        busy  <= 1'b1;
      end else if (busy) begin
        if (cnt_q <= {{(W-1){1'b0}}, 1'b1}) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // dpc_timer
`default_nettype wire

// File: dpc_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// port-level checks on the line interface controller
module dpc_chk (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // watched ports
  input wire logic spi_cs_n,
  input wire logic spi_sdo_oe,
  input wire logic pcm_clk,
  input wire logic serial_transmit_data,
  input wire logic line_ring,
  input wire logic link_enable,
  input wire logic line_tx_valid,
  input wire logic link_loop_cmd,
  input wire logic analog_loop_cmd,
  input wire logic ring_detect_output,
  input wire logic data_valid
);
  logic [8:0] idle_q;
  logic       pcm_q;
  logic [3:0] ring_q;

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  // cycles since the bit clock last moved; ring history covers sync latency
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      idle_q <= 9'h000;
      pcm_q  <= 1'b0;
      ring_q <= 4'h0;
    end else begin
      pcm_q  <= pcm_clk;
      ring_q <= {ring_q[2:0], line_ring};
      if (pcm_clk != pcm_q) idle_q <= 9'h000;
      else if (idle_q != 9'h1ff) idle_q <= idle_q + 9'h001;
    end
  end

  sequence s_released; !rst && $past(rst); endsequence
  sequence s_cs_idle; spi_cs_n [*4]; endsequence
  sequence s_quiet;
    !link_enable && !link_loop_cmd && !analog_loop_cmd && !ring_detect_output;
  endsequence

  property p_rst_quiet; s_released |-> s_quiet [*8]; endproperty
  property p_link_clk; link_enable |-> idle_q < 9'd300; endproperty
  property p_tx_link; line_tx_valid |-> link_enable || $past(link_enable); endproperty
  property p_tx_pulse; line_tx_valid |=> !line_tx_valid; endproperty
  // ring goes through the frame flag, so it trails the link by two cycles
  property p_ring_link; ring_detect_output |-> $past(link_enable, 2); endproperty
  property p_ring_src; ring_detect_output |-> |ring_q; endproperty
  property p_sdo_quiet; s_cs_idle |-> !spi_sdo_oe; endproperty
  // tx bits move only in the low half of the bit clock
  property p_tx_edge;
    $changed(serial_transmit_data) && data_valid |-> !$past(pcm_clk, 2);
  endproperty

  a_rst_quiet: assert property (p_rst_quiet) else $error("outputs active after reset");
  a_link_clk: assert property (p_link_clk) else $error("link on without bit clock");
  a_tx_link: assert property (p_tx_link) else $error("line word sent with link off");
  a_tx_pulse: assert property (p_tx_pulse) else $error("line valid longer than one cycle");
  a_ring_link: assert property (p_ring_link) else $error("ring output without link");
  a_ring_src: assert property (p_ring_src) else $error("ring output without ring");
  a_sdo_quiet: assert property (p_sdo_quiet) else $error("sdo driven while deselected");
  a_tx_edge: assert property (p_tx_edge) else $error("tx bit changed while clock high");
endmodule // dpc_chk
`default_nettype wire

// File: dpc_host.sv
`timescale 1ns/1ps
`default_nettype none
// host side of the pcm highway: bit clock, frame sync, data out and in
module dpc_host (
  // bench side
  input  wire logic       run,
  input  wire logic [7:0] host_word,
  output logic      [7:0] heard_word,
  // pcm highway
  output logic            pcm_clk,
  output logic            frame_sync_input,
  output logic            serial_receive_data,
  input  wire logic       serial_transmit_data
);
  logic [7:0] shift_q;
  int         bit_n;

  // bit clock runs whenever enabled, sleep included
  initial begin
    bit_n = 7;
    frame_sync_input = 1'b0;
    serial_receive_data = 1'b0;
    heard_word = 8'h00;
    shift_q = 8'h00;
    pcm_clk = 1'b0;
    #3;
    forever #40 pcm_clk = run ? ~pcm_clk : 1'b0;
  end

  // sync and data change on the fall, msb first, sync marks bit 0
  always @(negedge pcm_clk) begin
    bit_n = (bit_n + 1) % 8;
    frame_sync_input <= (bit_n == 0);
    serial_receive_data <= host_word[7 - bit_n];
  end

  // tx runs one bit behind: bits 1..7 then bit 0 of the next frame
  always @(posedge pcm_clk) begin
    shift_q <= {shift_q[6:0], serial_transmit_data};
    if (bit_n == 0) heard_word <= {shift_q[6:0], serial_transmit_data};
  end
endmodule // dpc_host
`default_nettype wire

// File: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// bench for the line interface controller
module tb_top;
  logic       clock, rst, spi_sclk, spi_cs_n, spi_sdi, run;
  logic       line_frame_ok, line_ring, line_offhook, line_dc_settled, line_power_ok;
  logic [7:0] host_word, line_rx_word;
  wire        spi_sdo, spi_sdo_oe, pcm_clk, frame_sync_input, serial_receive_data;
  wire        serial_transmit_data, link_enable, line_tx_valid, link_loop_cmd;
  wire        analog_loop_cmd, ring_detect_output, data_valid;
  wire  [7:0] line_tx_word, heard_word;
  int         n_fail, comparisons;
  logic [6:0] ra [9] = '{7'h01, 7'h02, 7'h06, 7'h0a, 7'h0c, 7'h11, 7'h19, 7'h21, 7'h05};
  logic [7:0] rv [9] = '{8'h00, 8'h02, 8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // short calibration counts keep the run small
  dpc_daa_ctrl #(.RCAL_CYCLES(50), .ADC_CYCLES(100), .LINK_CYCLES(200), .FD(2)) uut (
    .clock, .rst, .spi_sclk, .spi_cs_n, .spi_sdi, .spi_sdo, .spi_sdo_oe, .pcm_clk,
    .frame_sync_input, .serial_receive_data, .serial_transmit_data, .line_frame_ok,
    .line_ring, .line_offhook, .line_power_ok, .line_dc_settled, .line_rx_word,
    .link_enable, .line_tx_word, .line_tx_valid, .link_loop_cmd, .analog_loop_cmd,
    .ring_detect_output, .data_valid);
  dpc_host u_host (.run, .host_word, .heard_word, .pcm_clk, .frame_sync_input,
    .serial_receive_data, .serial_transmit_data);

  // clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one control frame, 10 clocks per sclk half, read bits taken before each rise
  task automatic xfer(input logic [15:0] f, output logic [7:0] rd);
    rd = 8'h00;
    spi_cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      spi_sdi = f[i];
      repeat (10) @(negedge clock);
      if (i < 8) rd[i] = spi_sdo;
      spi_sclk = 1'b1;
      repeat (10) @(negedge clock);
      spi_sclk = 1'b0;
    end
    repeat (10) @(negedge clock);
    spi_cs_n = 1'b1;
    repeat (10) @(negedge clock);
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    xfer({1'b0, a, d}, x);
  endtask

  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] v;
    xfer({1'b1, a, 8'h00}, v);
    chk($sformatf("reg %h", a), v, e);
  endtask

  task automatic count_low(input int w, output int n);
    n = 0;
    repeat (w) begin
      @(negedge clock);
      if (data_valid !== 1'b1) n++;
    end
  endtask

  // off-hook edge, dc settling held back sd cycles, low time expected near e
  task automatic cal(input int sd, input int e);
    int n;
    line_offhook = 1'b0;
    repeat (5) @(negedge clock);
    line_offhook = 1'b1;
    line_dc_settled = (sd == 0);
    fork
      count_low(500, n);
      begin
        repeat (sd) @(negedge clock);
        line_dc_settled = 1'b1;
      end
    join
    chk("cal cycles", n >= e && n <= e + 25, 1'b1);
  endtask

  // watchdog well past the expected quarter millisecond
  initial begin
    #700us;
    n_fail++;
    tally_and_finish;
  end

  initial begin
    int n;
    logic [7:0] v;
    {rst, spi_sclk, spi_cs_n, spi_sdi, run} = 5'b10100;
    {line_frame_ok, line_ring, line_offhook, line_dc_settled, line_power_ok} = 5'b00011;
    host_word = 8'h40;
    line_rx_word = 8'h3c;
    n_fail = 0;
    comparisons = 0;
    v = 8'h00;
    repeat (2) @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    foreach (ra[k]) rchk(ra[k], rv[k]);
    chk("link", link_enable, 1'b0);
    run = 1'b1;
    for (int i = 0; i < 30 && !v[0]; i++) xfer({1'b1, 7'h0c, 8'h00}, v);
    chk("lock", v[0], 1'b1);
    repeat (800) @(negedge clock);
    chk("startup loop", heard_word inside {8'h39, 8'h3a}, 1'b1);
    wr(7'h0a, 8'h01);
    host_word = 8'ha5;
    repeat (640) @(negedge clock);
    chk("digital loop", heard_word, 8'ha5);
    wr(7'h0a, 8'h00);
    host_word = 8'h7f;
    wr(7'h06, 8'h00);
    repeat (300) @(negedge clock);
    rchk(7'h0c, 8'h05);
    wr(7'h06, 8'h10);
    line_frame_ok = 1'b1;
    wr(7'h06, 8'h00);
    repeat (100) @(negedge clock);
    chk("link", link_enable, 1'b1);
    repeat (700) @(negedge clock);
    chk("line data", heard_word, 8'h3c);
    chk("line word", line_tx_word, 8'h7f);
    rchk(7'h0c, 8'h41);
    chk("valid", data_valid, 1'b1);
    cal(200, 300);
    wr(7'h19, 8'h20);
    cal(0, 100);
    // loss of line power also starts calibration, resistor step still disabled
    line_power_ok = 1'b0;
    count_low(200, n);
    line_power_ok = 1'b1;
    chk("power loss cal", n >= 100 && n <= 125, 1'b1);
    wr(7'h11, 8'h20);
    fork
      count_low(1000, n);
      begin
        wr(7'h11, 8'h60);
        wr(7'h11, 8'h20);
      end
    join
    chk("manual cal", n >= 100 && n <= 125, 1'b1);
    // one test mode at a time
    wr(7'h01, 8'h02);
    chk("link loop", link_loop_cmd, 1'b1);
    wr(7'h01, 8'h00);
    wr(7'h02, 8'h00);
    chk("analog loop", analog_loop_cmd, 1'b1);
    wr(7'h02, 8'h02);
    wr(7'h21, 8'h80);
    rchk(7'h21, 8'h80);
    chk("pcm loop", line_tx_word, 8'h35);
    chk("pcm loop tx", heard_word, 8'h35);
    wr(7'h21, 8'h00);
    line_ring = 1'b1;
    wr(7'h06, 8'h08);
    repeat (20) @(negedge clock);
    chk("sleep ring", ring_detect_output, 1'b1);
    chk("sleep link", link_enable, 1'b1);
    chk("sleep valid", data_valid, 1'b0);
    wr(7'h0a, 8'h01);
    rchk(7'h0a, 8'h00);
    repeat (300) @(negedge clock);
    chk("sleep tx", heard_word, 8'h00);
    rst = 1'b1;
    @(negedge clock);
    rst = 1'b0;
    repeat (4) @(negedge clock);
    rchk(7'h06, 8'h10);
    repeat (5000) @(negedge clock);
    wr(7'h06, 8'h00);
    repeat (20) @(negedge clock);
    chk("wake ring", ring_detect_output, 1'b1);
    wr(7'h06, 8'h18);
    repeat (20) @(negedge clock);
    chk("deep link", link_enable, 1'b0);
    chk("deep ring", ring_detect_output, 1'b0);
    chk("deep valid", data_valid, 1'b0);
    wr(7'h06, 8'h00);
    rchk(7'h06, 8'h18);
    tally_and_finish;
  end
endmodule // tb_top

bind dpc_daa_ctrl dpc_chk u_chk (.clock, .rst, .spi_cs_n, .spi_sdo_oe, .pcm_clk,
  .serial_transmit_data, .line_ring, .link_enable, .line_tx_valid, .link_loop_cmd,
  .analog_loop_cmd, .ring_detect_output, .data_valid);
`default_nettype wire
